/* hw/csi2_tx_port_control.sv */
`timescale 1ns/1ps
module csi2_tx_port_control (
   // System clock domain
   input wire logic sys_clk,
   input wire logic reset_n,
   // Register port
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic regRdValid,
   // Receive port status pins
   input wire logic [3:0] rxEnabled,
   input wire logic [3:0] rxVideoValid,
   input wire logic [1:0] txFault,
   output logic [1:0] passStatus,
   // Link clock domain
   input wire logic linkClk,
   input wire logic vidValid,
   input wire logic [7:0] vidData,
   input wire logic vidFrameEnd,
   output logic vidReady,
   // Transmit ports
   output logic [1:0][7:0] hsByte,
   output logic [1:0] hsValid,
   output logic [1:0] portOn,
   output logic [1:0][2:0] activeLanes,
   output logic [1:0] lpDataForce,
   output logic [1:0] lpClkForce,
   output logic [1:0] clkContinuous,
   output logic [1:0] calActive
);
   typedef struct packed {
      logic readPort;
      logic [1:0] writePorts;
      logic [1:0][7:0] ctl;
      logic [1:0][3:0] ctl2;
      logic [1:0] reqToggle;
      logic [1:0] doneSync1;
      logic [1:0] doneSync2;
      logic [1:0] doneSync3;
      logic [3:0] enSync1;
      logic [3:0] enSync2;
      logic [3:0] vldSync1;
      logic [3:0] vldSync2;
      logic [1:0] faultSync1;
      logic [1:0] faultSync2;
      logic [1:0] pass;
      logic [7:0] rdData;
      logic rdValid;
   } sys_state_t;

   typedef struct packed {
      logic [1:0][tx_port_pkg::CFG_WIDTH-1:0] cfgSync1;
      logic [1:0][tx_port_pkg::CFG_WIDTH-1:0] cfgSync2;
      logic [1:0] reqSync1;
      logic [1:0] reqSync2;
      logic [1:0] reqSeen;
      logic [1:0] doneToggle;
      tx_port_pkg::tx_state_t [1:0] st;
      logic [1:0][7:0] cnt;
      logic [1:0] single;
      logic [1:0] firstPkt;
      logic [1:0][7:0] hsByte;
      logic [1:0] hsValid;
   } link_state_t;

   sys_state_t s;
   sys_state_t next_s;
   link_state_t l;
   link_state_t next_l;
   logic linkRst1;
   logic linkRstN;
   logic [1:0] doneEdge;
   logic fifoValid;
   logic [tx_port_pkg::FIFO_WIDTH-1:0] fifoData;
   logic fifoPop;
   logic [1:0] inData;
   logic [1:0] on;

   // Reset is released into the link domain through two flops
   always_ff @(posedge linkClk) begin
      linkRst1 <= reset_n;
      linkRstN <= linkRst1;
   end

   fifo_buffer #(
      .WIDTH(tx_port_pkg::FIFO_WIDTH),
      .DEPTH(tx_port_pkg::FIFO_DEPTH)
   ) u_video_fifo (
      .clk(linkClk),
      .rstN(linkRstN),
      .inValid(vidValid),
      .inData({vidFrameEnd, vidData}),
      .inReady(vidReady),
      .outValid(fifoValid),
      .outData(fifoData),
      .outReady(fifoPop)
   );

   assign doneEdge = s.doneSync2 ^ s.doneSync3;

   always_comb begin
      logic hit;
      logic [3:0] v;
      hit = 1'b0;
      v = '0;
      next_s = s;
      next_s.doneSync1 = l.doneToggle;
      next_s.doneSync2 = s.doneSync1;
      next_s.doneSync3 = s.doneSync2;
      next_s.enSync1 = rxEnabled;
      next_s.enSync2 = s.enSync1;
      next_s.vldSync1 = rxVideoValid;
      next_s.vldSync2 = s.vldSync1;
      next_s.faultSync1 = txFault;
      next_s.faultSync2 = s.faultSync1;
      for (int p = 0; p < 2; p++) begin
         if (doneEdge[p]) begin
            next_s.ctl2[p][tx_port_pkg::CTL2_SINGLE_BIT] = 1'b0;
         end
      end
      if (regWr) begin
         case (regAddr)
            tx_port_pkg::ADDR_PAGE_SEL: begin
               next_s.readPort = regWrData[tx_port_pkg::PAGE_READ_BIT];
               next_s.writePorts = {regWrData[tx_port_pkg::PAGE_WR1_BIT], regWrData[tx_port_pkg::PAGE_WR0_BIT]};
            end
            tx_port_pkg::ADDR_CTL: begin
               for (int p = 0; p < 2; p++) begin
                  if (s.writePorts[p]) begin
                     next_s.ctl[p] = regWrData & tx_port_pkg::CTL_MASK;
                  end
               end
            end
            tx_port_pkg::ADDR_CTL_TWO: begin
               for (int p = 0; p < 2; p++) begin
                  if (s.writePorts[p]) begin
                     // A new request landing with the completion still wins
                     hit = regWrData[tx_port_pkg::CTL2_SINGLE_BIT] &&
                        (!s.ctl2[p][tx_port_pkg::CTL2_SINGLE_BIT] || doneEdge[p]);
                     next_s.ctl2[p] = regWrData[tx_port_pkg::CTL2_WIDTH-1:0];
                     if (hit) begin
                        next_s.reqToggle[p] = !s.reqToggle[p];
                     end
                  end
               end
            end
            default: begin
            end
         endcase
      end
      next_s.rdValid = regRd;
      case (regAddr)
         tx_port_pkg::ADDR_PAGE_SEL: next_s.rdData = {3'h0, s.readPort, 2'h0, s.writePorts};
         tx_port_pkg::ADDR_CTL: next_s.rdData = s.ctl[s.readPort];
         tx_port_pkg::ADDR_CTL_TWO: next_s.rdData = {4'h0, s.ctl2[s.readPort]};
         default: next_s.rdData = 8'h00;
      endcase
      if (!regRd) begin
         next_s.rdData = s.rdData;
      end
      v = s.vldSync2 & s.enSync2;
      for (int p = 0; p < 2; p++) begin
         if (s.ctl2[p][tx_port_pkg::CTL2_MODE_BIT]) begin
            hit = (s.enSync2 != 4'h0) && (v == s.enSync2);
         end else begin
            hit = v != 4'h0;
         end
         next_s.pass[p] = hit && s.ctl[p][tx_port_pkg::CTL_EN_BIT] && !s.faultSync2[p];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign regRdData = s.rdData;
   assign regRdValid = s.rdValid;
   assign passStatus = s.pass;

   // Link side: configuration is quasi-static, changed only with forwarding stopped
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         on[p] = l.cfgSync2[p][tx_port_pkg::CTL_EN_BIT];
         inData[p] = l.st[p] == tx_port_pkg::TX_DATA;
      end
   end
   // All enabled ports take the same byte, so one slow port stalls the buffer
   assign fifoPop = fifoValid && (on != 2'b00) && ((~on | inData) == 2'b11);

   always_comb begin
      logic [tx_port_pkg::CFG_WIDTH-1:0] c;
      logic [7:0] pat;
      c = '0;
      pat = '0;
      next_l = l;
      next_l.cfgSync1 = {{s.ctl2[1], s.ctl[1]}, {s.ctl2[0], s.ctl[0]}};
      next_l.cfgSync2 = l.cfgSync1;
      next_l.reqSync1 = s.reqToggle;
      next_l.reqSync2 = l.reqSync1;
      next_l.hsValid = 2'b00;
      for (int p = 0; p < 2; p++) begin
         c = l.cfgSync2[p];
         pat = c[tx_port_pkg::CFG_CTL2_LSB + tx_port_pkg::CTL2_INV_BIT] ?
            ~tx_port_pkg::CAL_PATTERN : tx_port_pkg::CAL_PATTERN;
         case (l.st[p])
            tx_port_pkg::TX_OFF: begin
               next_l.firstPkt[p] = 1'b0;
               next_l.cnt[p] = '0;
               if (on[p]) begin
                  next_l.st[p] = c[tx_port_pkg::CTL_CAL_BIT] ? tx_port_pkg::TX_INIT_CAL : tx_port_pkg::TX_IDLE;
               end
            end
            tx_port_pkg::TX_INIT_CAL, tx_port_pkg::TX_CAL: begin
               next_l.hsByte[p] = pat;
               next_l.hsValid[p] = 1'b1;
               next_l.cnt[p] = 8'(l.cnt[p] + 1'b1);
               if (l.cnt[p] == tx_port_pkg::CAL_LAST) begin
                  next_l.st[p] = tx_port_pkg::TX_IDLE;
                  next_l.cnt[p] = '0;
                  if (l.st[p] == tx_port_pkg::TX_CAL && l.single[p]) begin
                     next_l.doneToggle[p] = !l.doneToggle[p];
                  end
               end
            end
            tx_port_pkg::TX_IDLE: begin
               if (!on[p]) begin
                  next_l.st[p] = tx_port_pkg::TX_OFF;
               end else if (l.reqSync2[p] != l.reqSeen[p]) begin
                  next_l.st[p] = tx_port_pkg::TX_CAL;
                  next_l.single[p] = 1'b1;
                  next_l.reqSeen[p] = l.reqSync2[p];
               end else if (fifoValid) begin
                  next_l.st[p] = tx_port_pkg::TX_DATA;
               end
            end
            tx_port_pkg::TX_DATA: begin
               if (!on[p]) begin
                  next_l.st[p] = tx_port_pkg::TX_OFF;
               end else if (fifoPop) begin
                  next_l.hsByte[p] = fifoData[7:0];
                  next_l.hsValid[p] = 1'b1;
                  next_l.firstPkt[p] = 1'b1;
                  if (fifoData[tx_port_pkg::FE_BIT]) begin
                     next_l.single[p] = 1'b0;
                     next_l.st[p] = c[tx_port_pkg::CFG_CTL2_LSB + tx_port_pkg::CTL2_PER_BIT] ?
                        tx_port_pkg::TX_CAL : tx_port_pkg::TX_IDLE;
                  end
               end
            end
            default: next_l.st[p] = tx_port_pkg::TX_OFF;
         endcase
      end
   end

   always_ff @(posedge linkClk) begin
      if (!linkRstN) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   always_comb begin
      for (int p = 0; p < 2; p++) begin
         hsByte[p] = l.hsByte[p];
         hsValid[p] = l.hsValid[p];
         portOn[p] = on[p];
         activeLanes[p] = tx_port_pkg::lanes_of(l.cfgSync2[p][tx_port_pkg::CTL_LANE_LSB +: 2]);
         // Reserved force code behaves as normal operation
         lpDataForce[p] = l.cfgSync2[p][tx_port_pkg::CTL_LP_LSB +: 2] == tx_port_pkg::LP_DATA_ONLY ||
            l.cfgSync2[p][tx_port_pkg::CTL_LP_LSB +: 2] == tx_port_pkg::LP_DATA_CLK;
         lpClkForce[p] = l.cfgSync2[p][tx_port_pkg::CTL_LP_LSB +: 2] == tx_port_pkg::LP_DATA_CLK;
         clkContinuous[p] = l.cfgSync2[p][tx_port_pkg::CTL_CONT_BIT] && l.firstPkt[p];
         calActive[p] = l.st[p] == tx_port_pkg::TX_INIT_CAL || l.st[p] == tx_port_pkg::TX_CAL;
      end
   end

   chk_read_select: assert property (@(posedge sys_clk) disable iff (!reset_n)
      regRd && regAddr == tx_port_pkg::ADDR_CTL |=> regRdData == s.ctl[$past(s.readPort)])
      else $error("paged read returned wrong port");
   chk_write_both: assert property (@(posedge sys_clk) disable iff (!reset_n)
      regWr && regAddr == tx_port_pkg::ADDR_CTL && s.writePorts == 2'b11 |=> s.ctl[0] == s.ctl[1])
      else $error("broadcast write missed a port");
   chk_write_none: assert property (@(posedge sys_clk) disable iff (!reset_n)
      regWr && regAddr == tx_port_pkg::ADDR_CTL && s.writePorts == 2'b00 |=> $stable(s.ctl))
      else $error("write with no port enabled changed a port");
   chk_single_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
      doneEdge[0] && !(regWr && regAddr == tx_port_pkg::ADDR_CTL_TWO) |=> !s.ctl2[0][tx_port_pkg::CTL2_SINGLE_BIT])
      else $error("single request bit did not clear");
   chk_pass_any: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (s.vldSync2 & s.enSync2) == 4'h0 |=> !passStatus[0])
      else $error("pass asserted with no valid receiver");
   chk_init_cal: assert property (@(posedge linkClk) disable iff (!linkRstN)
      l.st[0] == tx_port_pkg::TX_OFF && on[0] && l.cfgSync2[0][tx_port_pkg::CTL_CAL_BIT]
      |=> ##1 (hsValid[0] && !inData[0])[*8])
      else $error("initial deskew not sent before data");
   chk_cont_clk: assert property (@(posedge linkClk) disable iff (!linkRstN)
      $rose(l.firstPkt[0]) |-> hsValid[0] && !$past(calActive[0]))
      else $error("continuous clock before first packet");
   chk_single_len: assert property (@(posedge linkClk) disable iff (!linkRstN)
      l.st[0] == tx_port_pkg::TX_IDLE && on[0] && l.reqSync2[0] != l.reqSeen[0]
      |=> l.st[0] == tx_port_pkg::TX_CAL ##127 l.st[0] == tx_port_pkg::TX_CAL ##1 l.st[0] != tx_port_pkg::TX_CAL)
      else $error("single deskew burst has wrong length");
   chk_periodic: assert property (@(posedge linkClk) disable iff (!linkRstN)
      inData[0] && on[0] && fifoPop && fifoData[tx_port_pkg::FE_BIT] &&
      l.cfgSync2[0][tx_port_pkg::CFG_CTL2_LSB + tx_port_pkg::CTL2_PER_BIT] |=> l.st[0] == tx_port_pkg::TX_CAL)
      else $error("no deskew after frame end");
   chk_pattern: assert property (@(posedge linkClk) disable iff (!linkRstN)
      l.st[0] == tx_port_pkg::TX_CAL |=> hsByte[0] == (l.cfgSync2[0][tx_port_pkg::CFG_CTL2_LSB +
      tx_port_pkg::CTL2_INV_BIT] ? 8'hAA : 8'h55))
      else $error("deskew payload wrong");
   chk_output_off: assert property (@(posedge linkClk) disable iff (!linkRstN)
      !on[0] && l.st[0] == tx_port_pkg::TX_OFF |=> !hsValid[0])
      else $error("disabled port sent data");
   cov_single: cover property (@(posedge linkClk) disable iff (!linkRstN) l.single[0] && calActive[0]);
   cov_frame_end: cover property (@(posedge linkClk) disable iff (!linkRstN) fifoPop && fifoData[tx_port_pkg::FE_BIT]);
   cov_pass_all: cover property (@(posedge sys_clk) disable iff (!reset_n)
      passStatus[1] && s.ctl2[1][tx_port_pkg::CTL2_MODE_BIT]);
endmodule : csi2_tx_port_control

/* hw/tx_port_pkg.sv */
package tx_port_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_PAGE_SEL = 8'h32;
   localparam logic [7:0] ADDR_CTL = 8'h33;
   localparam logic [7:0] ADDR_CTL_TWO = 8'h34;
   // Page select fields
   localparam int PAGE_READ_BIT = 4;
   localparam int PAGE_WR1_BIT = 1;
   localparam int PAGE_WR0_BIT = 0;
   // Control fields
   localparam int CTL_EN_BIT = 0;
   localparam int CTL_CONT_BIT = 1;
   localparam int CTL_LP_LSB = 2;
   localparam int CTL_LANE_LSB = 4;
   localparam int CTL_CAL_BIT = 6;
   localparam logic [7:0] CTL_MASK = 8'h7F;
   // Control two fields
   localparam int CTL2_PER_BIT = 0;
   localparam int CTL2_SINGLE_BIT = 1;
   localparam int CTL2_INV_BIT = 2;
   localparam int CTL2_MODE_BIT = 3;
   localparam int CTL2_WIDTH = 4;
   localparam logic [7:0] RESET_CTL = 8'h00;
   localparam logic [3:0] RESET_CTL2 = 4'h0;
   // Synchronised configuration word: control two sits above control
   localparam int CFG_WIDTH = 12;
   localparam int CFG_CTL2_LSB = 8;
   // Force encodings
   localparam logic [1:0] LP_NORMAL = 2'h0;
   localparam logic [1:0] LP_DATA_ONLY = 2'h1;
   localparam logic [1:0] LP_DATA_CLK = 2'h3;
   // Deskew pattern, sent MSB first so the first bit is zero
   localparam logic [7:0] CAL_PATTERN = 8'h55;
   localparam int CAL_BITS = 1024;
   localparam int BYTE_BITS = 8;
   localparam int CAL_WORDS = CAL_BITS / BYTE_BITS;
   localparam logic [7:0] CAL_LAST = 8'(CAL_WORDS - 1);
   // Video buffer
   localparam int FIFO_WIDTH = 9;
   localparam int FIFO_DEPTH = 16;
   localparam int FE_BIT = 8;
   typedef enum logic [2:0] {TX_OFF, TX_INIT_CAL, TX_IDLE, TX_DATA, TX_CAL} tx_state_t;

   function automatic logic [2:0] lanes_of(input logic [1:0] code);
      lanes_of = 3'(4 - int'(code));
   endfunction : lanes_of
endpackage : tx_port_pkg

/* hw/fifo_buffer.sv */
`timescale 1ns/1ps
module fifo_buffer #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstN,
   // Fill side
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   // Drain side
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [CW-1:0] count;
   } fifo_state_t;
   fifo_state_t s;
   fifo_state_t next_s;
   logic push;
   logic pop;

   assign inReady = s.count != FULL;
   assign outValid = s.count != '0;
   assign outData = s.mem[s.rd];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = inData;
         next_s.wr = PW'(s.wr + 1'b1);
      end
      if (pop) begin
         next_s.rd = PW'(s.rd + 1'b1);
      end
      next_s.count = CW'(s.count + CW'(push) - CW'(pop));
   end

   always_ff @(posedge clk) begin
      if (!rstN) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   chk_fifo_bounds: assert property (@(posedge clk) disable iff (!rstN)
      s.count <= FULL) else $error("fifo count beyond depth");
endmodule : fifo_buffer

/* testbench/csi_rx_model.sv */
`timescale 1ns/1ps
module csi_rx_model (
   // Link side
   input wire logic linkClk,
   input wire logic [1:0][7:0] hsByte,
   input wire logic [1:0] hsValid,
   input wire logic [1:0] calActive,
   // Expected deskew polarity per port
   input wire logic [1:0] calInv,
   // Tallies
   output int calCnt [2],
   output int badCnt [2],
   output int preCal [2]
);
   logic [7:0] got [2][$];
   // Byte on the lanes lags the state that made it by one cycle
   logic [1:0] calPrev = 2'b00;
   initial begin
      for (int p = 0; p < 2; p++) begin
         calCnt[p] = 0;
         badCnt[p] = 0;
         preCal[p] = -1;
      end
   end
   // No back-pressure on a real receiver, so every valid byte is taken
   always @(posedge linkClk) begin
      for (int p = 0; p < 2; p++) begin
         if (hsValid[p] === 1'b1 && calPrev[p] === 1'b1) begin
            calCnt[p]++;
            if (hsByte[p] !== (calInv[p] ? 8'hAA : 8'h55)) begin
               badCnt[p]++;
            end
         end else if (hsValid[p] === 1'b1) begin
            if (got[p].size() == 0) begin
               preCal[p] = calCnt[p];
            end
            got[p].push_back(hsByte[p]);
         end
      end
      calPrev <= calActive;
   end
endmodule : csi_rx_model

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] regRdData;
   logic regRdValid;
   logic [3:0] rxEnabled = 4'h0;
   logic [3:0] rxVideoValid = 4'h0;
   logic [1:0] txFault = 2'h0;
   logic [1:0] passStatus;
   logic linkClk = 1'b0;
   logic vidValid = 1'b0;
   logic [7:0] vidData = 8'h00;
   logic vidFrameEnd = 1'b0;
   logic vidReady;
   logic [1:0][7:0] hsByte;
   logic [1:0][2:0] activeLanes;
   logic [1:0] hsValid, portOn, lpDataForce, lpClkForce, clkContinuous, calActive;
   int calCnt [2];
   int badCnt [2];
   int preCal [2];
   int error_cnt = 0;
   int n_compared = 0;
   int seed = 13;
   int cyc = 0;
   logic [7:0] frame [$];
   logic [7:0] a, b;
   logic [3:0] en, vv;
   logic [1:0] ep;

   always #12.5 sys_clk = ~sys_clk;
   initial begin
      #7;
      forever #40 linkClk = ~linkClk;
   end

   csi2_tx_port_control dut (.sys_clk(sys_clk), .reset_n(reset_n), .regWr(regWr), .regRd(regRd),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
      .rxEnabled(rxEnabled), .rxVideoValid(rxVideoValid), .txFault(txFault), .passStatus(passStatus),
      .linkClk(linkClk), .vidValid(vidValid), .vidData(vidData), .vidFrameEnd(vidFrameEnd),
      .vidReady(vidReady), .hsByte(hsByte), .hsValid(hsValid), .portOn(portOn),
      .activeLanes(activeLanes), .lpDataForce(lpDataForce), .lpClkForce(lpClkForce),
      .clkContinuous(clkContinuous), .calActive(calActive));
   csi_rx_model rx (.linkClk(linkClk), .hsByte(hsByte), .hsValid(hsValid), .calActive(calActive),
      .calInv(2'b10), .calCnt(calCnt), .badCnt(badCnt), .preCal(preCal));

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= ad;
      regWrData <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask : wr
   // A missing valid pulse turns into a forced mismatch
   task automatic rd(input logic [7:0] ad, input logic [7:0] exp, input string nm);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= ad;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      chk(nm, 16'(exp), 16'(regRdValid === 1'b1 ? regRdData : ~exp));
   endtask : rd
   task automatic lw(input int n);
      repeat (n) @(posedge linkClk);
   endtask : lw
   task automatic push(input logic [7:0] d, input logic fe);
      @(posedge linkClk);
      vidValid <= 1'b1;
      vidData <= d;
      vidFrameEnd <= fe;
      do begin
         @(posedge linkClk);
      end while (vidReady !== 1'b1);
      vidValid <= 1'b0;
   endtask : push
   task automatic test_done;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         test_done;
      end
   end

   initial begin
      // Link reset needs two of its own edges, so hold well past two cycles
      repeat (14) @(posedge sys_clk);
      reset_n <= 1'b1;
      lw(4);
      rd(8'h32, 8'h00, "page reset");
      rd(8'h33, tx_port_pkg::RESET_CTL, "ctl reset");
      rd(8'h34, 8'(tx_port_pkg::RESET_CTL2), "ctl2 reset");
      rd(8'h35, 8'h00, "unmapped");
      wr(8'h32, 8'h03);
      for (int i = 0; i < 4; i++) begin
         ep = 2'(i);
         wr(8'h33, 8'(i * 20));
         lw(6);
         chk("lanes0", 16'(4 - i), 16'(activeLanes[0]));
         chk("lanes1", 16'(4 - i), 16'(activeLanes[1]));
         chk("lp force", 16'({ep[0], ep[0], &ep, &ep}), 16'({lpDataForce, lpClkForce}));
      end
      a = 8'($random(seed)) & 8'h3C;
      b = a ^ 8'h14;
      wr(8'h33, a);
      wr(8'h32, 8'h01);
      wr(8'h33, b);
      wr(8'h32, 8'h00);
      wr(8'h33, ~b & 8'h3C);
      wr(8'h34, 8'h08);
      rd(8'h33, b, "ctl p0");
      rd(8'h34, 8'h00, "ctl2 p0");
      wr(8'h32, 8'hFF);
      rd(8'h32, 8'h13, "page sel");
      rd(8'h33, a, "ctl p1");
      wr(8'h34, 8'hF0);
      rd(8'h34, 8'h00, "ctl2 reserved");
      for (int i = 0; i < 20; i++) begin
         frame.push_back(8'($random(seed)));
      end
      for (int i = 0; i < 16; i++) begin
         push(frame[i], 1'b0);
      end
      lw(2);
      chk("fifo full", 16'h0000, 16'(vidReady));
      chk("port off", 16'h0000, 16'(portOn));
      // Ports enabled while nothing flows; initial deskew set as for top rate
      wr(8'h32, 8'h01);
      wr(8'h33, 8'h43);
      wr(8'h32, 8'h02);
      wr(8'h34, 8'h0D);
      wr(8'h33, 8'h41);
      lw(20);
      chk("port on", 16'h0003, 16'(portOn));
      chk("cont early", 16'h0000, 16'(clkContinuous));
      for (int i = 16; i < 20; i++) begin
         push(frame[i], i == 19);
      end
      lw(300);
      for (int p = 0; p < 2; p++) begin
         chk("init cal", 16'(tx_port_pkg::CAL_WORDS), 16'(preCal[p]));
         chk("cal bytes", 16'(tx_port_pkg::CAL_WORDS * (p + 1)), 16'(calCnt[p]));
         chk("bad cal", 16'h0000, 16'(badCnt[p]));
         chk("frame len", 16'(frame.size()), 16'(rx.got[p].size()));
         for (int i = 0; i < 20; i++) begin
            chk("data", 16'(frame[i]), 16'(rx.got[p][i]));
         end
      end
      chk("cont late", 16'h0001, 16'(clkContinuous));
      wr(8'h32, 8'h01);
      wr(8'h34, 8'h02);
      lw(200);
      chk("single cal", 16'(tx_port_pkg::CAL_WORDS * 2), 16'(calCnt[0]));
      chk("single bad", 16'h0000, 16'(badCnt[0]));
      rd(8'h34, 8'h00, "single clear");
      for (int i = 0; i < 8; i++) begin
         en = 4'($random(seed)) | 4'h1;
         vv = 4'($random(seed));
         @(posedge sys_clk);
         rxEnabled <= en;
         rxVideoValid <= vv;
         txFault <= (i < 4) ? 2'h0 : 2'($random(seed));
         repeat (12) @(posedge sys_clk);
         ep[0] = (|(en & vv)) & ~txFault[0];
         ep[1] = ((en & vv) == en) & ~txFault[1];
         chk("pass", 16'(ep), 16'(passStatus));
      end
      test_done;
   end
endmodule : testbench
